// >>> ipv_pkg.sv
package ipv_pkg;

  // ==========================================================
  // sizes
  localparam int IPV_NUM_SRC = 21;
  localparam int IPV_NUM_NMI = 2;
  localparam int IPV_IDX_W = 5;
  localparam int IPV_PC_W = 16;
  localparam int IPV_SEG_W = 4;
  localparam int IPV_PSW_W = 8;
  localparam int IPV_ADDR_W = 8;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] IPV_FLAGS_OFS = 8'h00;
  localparam logic [7:0] IPV_ENABLE_OFS = 8'h04;
  localparam logic [7:0] IPV_CTRL_OFS = 8'h08;
  localparam logic [7:0] IPV_STATE_OFS = 8'h0C;
  localparam logic [7:0] IPV_SAVE1_OFS = 8'h10;
  localparam logic [7:0] IPV_SAVE2_OFS = 8'h14;

  // ==========================================================
  // field positions
  localparam int IPV_CTRL_GATE_BIT = 0;
  localparam int IPV_ST_DEPTH_LSB = 8;
  localparam int IPV_ST_BUSY_BIT = 12;
  localparam int IPV_ST_HOLD_BIT = 13;
  localparam int IPV_SV_SEG_LSB = 16;
  localparam int IPV_SV_PSW_LSB = 20;
  // position of the gate copy inside a saved status word
  localparam int IPV_PSW_GATE_BIT = 3;

  // ==========================================================
  // reset values, maskable enable set and depth levels
  localparam logic [20:0] IPV_FLAGS_RST = 21'h000000;
  localparam logic [20:0] IPV_ENABLE_RST = 21'h000000;
  localparam logic [20:0] IPV_MASKABLE = 21'h1FFFFC;
  localparam logic IPV_GATE_RST = 1'b0;
  localparam logic [1:0] IPV_DEPTH_RST = 2'h0;
  localparam logic [1:0] IPV_DEPTH_L1 = 2'h1;
  localparam logic [1:0] IPV_DEPTH_L2 = 2'h2;

  // ==========================================================
  // vector table, rank 0 is highest
  localparam logic [15:0] IPV_VECTORS [0:20] = '{
    16'h0008, 16'h000A, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
    16'h0020, 16'h0024, 16'h002E, 16'h0030, 16'h0032, 16'h0040,
    16'h004A, 16'h0058, 16'h005A, 16'h0060, 16'h0068, 16'h006A,
    16'h006E, 16'h0070, 16'h0076
  };

  // ==========================================================
  // entry sequence
  typedef enum logic [2:0] {
    IPV_IDLE,
    IPV_SAVE_PC,
    IPV_SAVE_SEG,
    IPV_SAVE_PSW,
    IPV_CLR_GATE,
    IPV_SET_LEVEL,
    IPV_LOAD_PC
  } ipv_state_type;

endpackage : ipv_pkg

// >>> ipv_arb_if.sv
`timescale 1ns/100ps
`default_nettype none

interface ipv_arb_if;
  import ipv_pkg::*;
  logic [IPV_NUM_SRC-1:0] eligible;
  logic found;
  logic [IPV_IDX_W-1:0] index;
  logic [15:0] vector;

  modport client (output eligible, input found, input index, input vector);
  modport ranker (input eligible, output found, output index, output vector);
endinterface : ipv_arb_if

`default_nettype wire

// >>> ipv_ranker.sv
`timescale 1ns/100ps
`default_nettype none

module ipv_ranker
  import ipv_pkg::*;
(
  ipv_arb_if.ranker arb // eligible requests in, winner out
);

  // ==========================================================
  // fixed rank: scan downward so the lowest index wins
  always_comb begin
    arb.found = 1'b0;
    arb.index = '0;
    arb.vector = IPV_VECTORS[0];
    for (int i = IPV_NUM_SRC - 1; i >= 0; i--) begin
      if (arb.eligible[i]) begin
        arb.found = 1'b1;
        arb.index = IPV_IDX_W'(i);
        arb.vector = IPV_VECTORS[i];
      end
    end
  end

endmodule : ipv_ranker

`default_nettype wire

// >>> ipv_controller.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ipv_controller
  import ipv_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [IPV_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [IPV_NUM_SRC-1:0] source_events, // one-cycle event per source
  input wire logic instr_done, // cpu finished an instruction
  input wire logic dsr_prefix_done, // that instruction was a segment prefix
  input wire logic soft_trap_instr, // soft trap executes, pulse
  input wire logic [IPV_PC_W-1:0] soft_trap_vector, // vector from operand
  input wire logic return_from_trap_instr, // return executes, pulse
  input wire logic [IPV_PC_W-1:0] cpu_pc, // current return address
  input wire logic [IPV_SEG_W-1:0] code_segment, // current code segment
  input wire logic [IPV_PSW_W-1:0] status_word, // current status word
  output logic take_strobe, // hardware request accepted, pulse
  output logic [IPV_IDX_W-1:0] take_source, // accepted source rank
  output logic [IPV_PC_W-1:0] take_vector, // accepted source vector
  output logic shift_busy, // entry sequence running
  output logic pc_load, // cpu loads pc, pulse
  output logic [IPV_PC_W-1:0] pc_load_value, // new pc
  output logic status_load, // cpu loads status word, pulse
  output logic [IPV_PSW_W-1:0] status_load_value, // restored status word
  output logic master_irq_gate, // master enable
  output logic [1:0] exception_depth // current exception level
);

  // ==========================================================
  // state
  logic [IPV_NUM_SRC-1:0] source_request_flags;
  logic [IPV_NUM_SRC-1:0] source_enable_bits;
  logic [IPV_PC_W-1:0] return_addr_level1;
  logic [IPV_PC_W-1:0] return_addr_level2;
  logic [IPV_SEG_W-1:0] saved_segment_level1;
  logic [IPV_SEG_W-1:0] saved_segment_level2;
  logic [IPV_PSW_W-1:0] saved_status_level1;
  logic [IPV_PSW_W-1:0] saved_status_level2;
  logic write_hold;
  logic entry_level2;
  logic [IPV_PC_W-1:0] entry_vector;
  ipv_state_type state;
  ipv_state_type next_state;

  ipv_arb_if arb ();

  ipv_ranker u_ranker (
    .arb(arb.ranker)
  );

  // ==========================================================
  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pwrite;
  wire hit_flags = (paddr == IPV_FLAGS_OFS);
  wire hit_enable = (paddr == IPV_ENABLE_OFS);
  wire hit_ctrl = (paddr == IPV_CTRL_OFS);
  wire hit_state = (paddr == IPV_STATE_OFS);
  wire hit_save1 = (paddr == IPV_SAVE1_OFS);
  wire hit_save2 = (paddr == IPV_SAVE2_OFS);
  wire addr_ok = hit_flags | hit_enable | hit_ctrl | hit_state | hit_save1 | hit_save2;
  wire wr_flags = apb_write & hit_flags;
  wire wr_enable = apb_write & hit_enable;
  wire wr_ctrl = apb_write & hit_ctrl;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ==========================================================
  // read mux, sampled in the setup cycle
  wire [31:0] rd_flags = {11'h000, source_request_flags};
  wire [31:0] rd_enable = {11'h000, source_enable_bits};
  wire [31:0] rd_ctrl = {31'h00000000, master_irq_gate};
  wire [31:0] rd_state = {18'h00000, write_hold, shift_busy, 2'h0, exception_depth,
                          3'h0, take_source};
  wire [31:0] rd_save1 = {4'h0, saved_status_level1, saved_segment_level1,
                          return_addr_level1};
  wire [31:0] rd_save2 = {4'h0, saved_status_level2, saved_segment_level2,
                          return_addr_level2};
  wire [31:0] rd_mux = hit_flags ? rd_flags :
                       hit_enable ? rd_enable :
                       hit_ctrl ? rd_ctrl :
                       hit_state ? rd_state :
                       hit_save1 ? rd_save1 :
                       hit_save2 ? rd_save2 : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // acceptance decision
  assign shift_busy = (state != IPV_IDLE);

  // the shift sequence keeps state busy, and instruction boundaries that
  // arrive while it runs are ignored until the state returns to idle
  wire boundary_ok = instr_done & ~shift_busy;
  wire window_open = boundary_ok & ~dsr_prefix_done & ~write_hold;
  // a trap instruction owns its boundary; hardware waits for the next
  wire soft_take = soft_trap_instr & ~shift_busy;
  wire hw_take = window_open & arb.found & ~soft_trap_instr;
  wire ret_go = return_from_trap_instr & ~shift_busy & ~soft_trap_instr;
  wire hw_nmi = (arb.index < IPV_IDX_W'(IPV_NUM_NMI));

  // one instruction of grace after software touches flags or enables
  wire next_write_hold = wr_flags | wr_enable | (write_hold & ~instr_done);

  // ==========================================================
  // per-source flags and eligibility
  logic [IPV_NUM_SRC-1:0] next_flags;

  for (genvar i = 0; i < IPV_NUM_SRC; i++) begin : g_src
    wire taken_here = hw_take & (arb.index == IPV_IDX_W'(i));
    if (i < IPV_NUM_NMI) begin : g_nmi
      assign arb.eligible[i] = source_request_flags[i];
    end else begin : g_mask
      assign arb.eligible[i] = source_request_flags[i] & source_enable_bits[i]
                               & master_irq_gate;
    end
    // event set wins over both software and acceptance clears
    assign next_flags[i] = source_events[i] |
                           (wr_flags ? pwdata[i] :
                            (source_request_flags[i] & ~taken_here));
  end

  wire [IPV_NUM_SRC-1:0] next_enables = wr_enable ? (pwdata[IPV_NUM_SRC-1:0] & IPV_MASKABLE)
                                                  : source_enable_bits;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_request_flags <= IPV_FLAGS_RST;
      source_enable_bits <= IPV_ENABLE_RST;
      write_hold <= 1'b0;
    end else begin
      source_request_flags <= next_flags;
      source_enable_bits <= next_enables;
      write_hold <= next_write_hold;
    end
  end

  // ==========================================================
  // take outputs
  // source and vector hold until the next take, so software can still
  // see in the state register which source was accepted last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_strobe <= 1'b0;
      take_source <= '0;
      take_vector <= '0;
    end else begin
      take_strobe <= hw_take;
      if (hw_take) begin
        take_source <= arb.index;
        take_vector <= arb.vector;
      end
    end
  end

  // ==========================================================
  // entry sequence, one step per cycle in the documented order
  always_comb begin
    next_state = state;
    unique case (state)
      IPV_IDLE: begin
        if (soft_take || hw_take) begin
          next_state = IPV_SAVE_PC;
        end
      end
      IPV_SAVE_PC: next_state = IPV_SAVE_SEG;
      IPV_SAVE_SEG: next_state = IPV_SAVE_PSW;
      IPV_SAVE_PSW: begin
        next_state = entry_level2 ? IPV_SET_LEVEL : IPV_CLR_GATE;
      end
      IPV_CLR_GATE: next_state = IPV_SET_LEVEL;
      IPV_SET_LEVEL: next_state = IPV_LOAD_PC;
      IPV_LOAD_PC: next_state = IPV_IDLE;
      // the eighth code of the state register is never entered; recover to idle
      default: next_state = IPV_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IPV_IDLE;
      entry_level2 <= 1'b0;
      entry_vector <= '0;
    end else begin
      state <= next_state;
      if (soft_take) begin
        entry_level2 <= 1'b0;
        entry_vector <= soft_trap_vector;
      end else if (hw_take) begin
        entry_level2 <= hw_nmi;
        entry_vector <= arb.vector;
      end
    end
  end

  // ==========================================================
  // exception save registers; cpu holds pc, segment and status steady
  // while shift_busy is high
  wire [IPV_PSW_W-1:0] status_with_gate = (status_word & ~(IPV_PSW_W'(1) << IPV_PSW_GATE_BIT))
                                          | (IPV_PSW_W'(master_irq_gate) << IPV_PSW_GATE_BIT);

  // one enable per step and level; a level-2 entry must never touch
  // the level-1 frame, which may still belong to an unfinished handler
  wire save_pc_l1 = (state == IPV_SAVE_PC) & ~entry_level2;
  wire save_pc_l2 = (state == IPV_SAVE_PC) & entry_level2;
  wire save_seg_l1 = (state == IPV_SAVE_SEG) & ~entry_level2;
  wire save_seg_l2 = (state == IPV_SAVE_SEG) & entry_level2;
  wire save_psw_l1 = (state == IPV_SAVE_PSW) & ~entry_level2;
  wire save_psw_l2 = (state == IPV_SAVE_PSW) & entry_level2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_addr_level1 <= '0;
    end else if (save_pc_l1) begin
      return_addr_level1 <= cpu_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_addr_level2 <= '0;
    end else if (save_pc_l2) begin
      return_addr_level2 <= cpu_pc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_segment_level1 <= '0;
    end else if (save_seg_l1) begin
      saved_segment_level1 <= code_segment;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_segment_level2 <= '0;
    end else if (save_seg_l2) begin
      saved_segment_level2 <= code_segment;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_status_level1 <= '0;
    end else if (save_psw_l1) begin
      saved_status_level1 <= status_with_gate;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_status_level2 <= '0;
    end else if (save_psw_l2) begin
      saved_status_level2 <= status_with_gate;
    end
  end

  // ==========================================================
  // gate and depth
  wire ret_from_l2 = (exception_depth == IPV_DEPTH_L2);
  wire [IPV_PSW_W-1:0] ret_status = ret_from_l2 ? saved_status_level2 : saved_status_level1;
  wire [IPV_PC_W-1:0] ret_addr = ret_from_l2 ? return_addr_level2 : return_addr_level1;

  // hardware clear of the gate outranks a software write in the same cycle
  wire next_gate = (state == IPV_CLR_GATE) ? 1'b0 :
                   ret_go ? ret_status[IPV_PSW_GATE_BIT] :
                   wr_ctrl ? pwdata[IPV_CTRL_GATE_BIT] : master_irq_gate;

  wire [1:0] next_depth = (state == IPV_SET_LEVEL) ?
                          (entry_level2 ? IPV_DEPTH_L2 : IPV_DEPTH_L1) :
                          (ret_go && exception_depth != IPV_DEPTH_RST) ?
                          exception_depth - 2'h1 : exception_depth;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_irq_gate <= IPV_GATE_RST;
      exception_depth <= IPV_DEPTH_RST;
    end else begin
      master_irq_gate <= next_gate;
      exception_depth <= next_depth;
    end
  end

  // ==========================================================
  // pc and status loads towards the cpu
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load <= 1'b0;
      pc_load_value <= '0;
      status_load <= 1'b0;
      status_load_value <= '0;
    end else begin
      pc_load <= (state == IPV_SET_LEVEL) | ret_go;
      status_load <= ret_go;
      if (state == IPV_SET_LEVEL) begin
        pc_load_value <= entry_vector;
      end else if (ret_go) begin
        pc_load_value <= ret_addr;
      end
      if (ret_go) begin
        status_load_value <= ret_status;
      end
    end
  end

endmodule : ipv_controller

`default_nettype wire

// >>> ipv_controller_sva.sv
`timescale 1ns/100ps
`default_nettype none

module ipv_sva
  import ipv_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic instr_done, // boundary
  input wire logic dsr_prefix_done, // prefix boundary
  input wire logic soft_trap_instr, // trap pulse
  input wire logic return_from_trap_instr, // return pulse
  input wire logic take_strobe, // take pulse
  input wire logic [IPV_IDX_W-1:0] take_source, // taken rank
  input wire logic [IPV_PC_W-1:0] take_vector, // taken vector
  input wire logic shift_busy, // entry running
  input wire logic pc_load, // pc load pulse
  input wire logic [IPV_PC_W-1:0] pc_load_value, // new pc
  input wire logic status_load, // status load pulse
  input wire logic master_irq_gate, // gate
  input wire logic [1:0] exception_depth // level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_take_pulse;
    take_strobe |=> !take_strobe;
  endproperty
  a_take_pulse: assert property (p_take_pulse)
    else $error("take strobe wider than one cycle");
  property p_take_boundary;
    take_strobe |-> $past(instr_done) && !$past(dsr_prefix_done);
  endproperty
  a_take_boundary: assert property (p_take_boundary)
    else $error("take without a plain boundary");
  property p_l1_entry;
    take_strobe && take_source > 5'h01 |-> ##5 (pc_load && pc_load_value == take_vector
      && exception_depth == 2'h1 && !master_irq_gate);
  endproperty
  a_l1_entry: assert property (p_l1_entry)
    else $error("maskable entry wrong");
  property p_l2_entry;
    take_strobe && take_source < 5'h02 |-> ##4 (pc_load && pc_load_value == take_vector
      && exception_depth == 2'h2);
  endproperty
  a_l2_entry: assert property (p_l2_entry)
    else $error("nonmaskable entry wrong");
  property p_l2_gate;
    take_strobe && take_source < 5'h02 |=> $stable(master_irq_gate)[*4];
  endproperty
  a_l2_gate: assert property (p_l2_gate)
    else $error("gate touched by nonmaskable entry");
  property p_gate_mask;
    take_strobe && take_source > 5'h01 |-> $past(master_irq_gate);
  endproperty
  a_gate_mask: assert property (p_gate_mask)
    else $error("maskable take with gate low");
  property p_busy_hold;
    shift_busy && instr_done |=> !take_strobe;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("take during entry sequence");
  property p_ret;
    return_from_trap_instr && !shift_busy && !soft_trap_instr |=> pc_load && status_load;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not restore");
endmodule : ipv_sva

`default_nettype wire

// >>> ipv_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module ipv_cpu_model
  import ipv_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic run, // let instructions retire
  input wire logic shift_busy, // entry running
  input wire logic pc_load, // load pc
  input wire logic [IPV_PC_W-1:0] pc_load_value, // new pc
  input wire logic status_load, // load status
  input wire logic [IPV_PSW_W-1:0] status_load_value, // restored status
  output logic instr_done, // boundary pulse
  output logic [IPV_PC_W-1:0] cpu_pc, // pc
  output logic [IPV_SEG_W-1:0] code_segment, // segment
  output logic [IPV_PSW_W-1:0] status_word // status
);
  assign code_segment = 4'h3;
  // boundaries keep coming during entry so the hold-off is really exercised
  // modelled handlers never nest or call, so no stacking is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_done <= 1'b0;
      cpu_pc <= 16'h0100;
      status_word <= 8'h5A;
    end else begin
      instr_done <= run && !instr_done;
      if (pc_load)
        cpu_pc <= pc_load_value;
      else if (instr_done && !shift_busy)
        cpu_pc <= cpu_pc + 16'h0002;
      if (status_load)
        status_word <= status_load_value;
    end
  end
endmodule : ipv_cpu_model

`default_nettype wire

// >>> ipv_controller_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module ipv_controller_tb_top;
  import ipv_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, instr_done, dsr_prefix_done, run, err;
  logic soft_trap_instr, return_from_trap_instr, take_strobe, shift_busy, pc_load;
  logic status_load, master_irq_gate, pready, pslverr;
  logic [IPV_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] source_events, left;
  logic [15:0] soft_trap_vector, cpu_pc, take_vector, pc_load_value, tk_vec, pc0;
  logic [IPV_SEG_W-1:0] code_segment;
  logic [IPV_PSW_W-1:0] status_word, status_load_value;
  logic [IPV_IDX_W-1:0] take_source, tk_src;
  logic [1:0] exception_depth;
  int n_errors = 0, comparisons = 0, n_bound = 0, n_take = 0, tk_bound = 0, mark;
  localparam int RK [0:7] = '{6, 7, 8, 11, 12, 16, 17, 20};
  localparam logic [15:0] VC [0:7] = '{16'h0020, 16'h0024, 16'h002E, 16'h0040,
    16'h004A, 16'h0068, 16'h006A, 16'h0076};
  localparam logic [20:0] EV = 21'h1319C0;

  ipv_controller ipv_controller_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .source_events, .instr_done, .dsr_prefix_done,
    .soft_trap_instr, .soft_trap_vector, .return_from_trap_instr, .cpu_pc, .code_segment,
    .status_word, .take_strobe, .take_source, .take_vector, .shift_busy, .pc_load,
    .pc_load_value, .status_load, .status_load_value, .master_irq_gate, .exception_depth);
  ipv_cpu_model ipv_cpu_model_inst (.pclk, .presetn, .run, .shift_busy, .pc_load,
    .pc_load_value, .status_load, .status_load_value, .instr_done, .cpu_pc, .code_segment,
    .status_word);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (instr_done === 1'b1) n_bound <= n_bound + 1;
    if (take_strobe === 1'b1) begin
      n_take <= n_take + 1;
      tk_src <= take_source;
      tk_vec <= take_vector;
      tk_bound <= n_bound;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fire(input logic [20:0] ev);
    @(posedge pclk);
    source_events <= ev;
    @(posedge pclk);
    source_events <= '0;
  endtask : fire

  task automatic go();
    mark = n_bound;
    run <= 1'b1;
  endtask : go

  task automatic settle();
    repeat (8) @(posedge pclk);
    run <= 1'b0;
  endtask : settle

  // nb of 0 skips the boundary count, used where the cpu phase is free
  task automatic wait_take(input int src, input logic [15:0] vec, input int nb);
    int t0;
    t0 = n_take;
    repeat (100) if (n_take == t0) begin
      @(posedge pclk);
      #1;
    end
    chk("take count", t0 + 1, n_take);
    chk("take source", src, 32'(tk_src));
    chk("take vector", 32'(vec), 32'(tk_vec));
    if (nb > 0) chk("boundaries", nb, tk_bound - mark);
  endtask : wait_take

  task automatic wait_load();
    int i;
    i = 0;
    #1;
    while (pc_load !== 1'b1 && i < 20) begin
      @(posedge pclk);
      #1;
      i++;
    end
    chk("pc load", 1, 32'(pc_load));
  endtask : wait_load

  task automatic t_reset();
    apb(1'b0, IPV_FLAGS_OFS, 0);
    chk("flags", 32'(IPV_FLAGS_RST), rd);
    apb(1'b0, IPV_ENABLE_OFS, 0);
    chk("enable", 32'(IPV_ENABLE_RST), rd);
    apb(1'b0, IPV_CTRL_OFS, 0);
    chk("ctrl", 32'(IPV_GATE_RST), rd);
    apb(1'b0, 8'h40, 0);
    chk("unmapped error", 1, 32'(err));
  endtask : t_reset

  task automatic t_trap();
    apb(1'b1, IPV_CTRL_OFS, 1);
    pc0 = cpu_pc;
    soft_trap_instr <= 1'b1;
    soft_trap_vector <= 16'h0044; // slot no source uses, kept filled by software
    @(posedge pclk);
    soft_trap_instr <= 1'b0;
    wait_load();
    chk("trap pc", 32'h44, 32'(pc_load_value));
    chk("trap depth", 1, 32'(exception_depth));
    chk("trap gate", 0, 32'(master_irq_gate));
    chk("trap no take", 0, n_take);
    @(posedge pclk);
    return_from_trap_instr <= 1'b1;
    @(posedge pclk);
    return_from_trap_instr <= 1'b0;
    wait_load();
    chk("return pc", 32'(pc0), 32'(pc_load_value));
    chk("return status", 32'h5A, 32'(status_load_value));
    @(posedge pclk);
    #1;
    chk("return gate", 1, 32'(master_irq_gate));
  endtask : t_trap

  task automatic t_mask();
    fire(EV);
    apb(1'b1, IPV_ENABLE_OFS, 32'(IPV_MASKABLE));
    apb(1'b1, IPV_CTRL_OFS, 0);
    go();
    repeat (20) @(posedge pclk);
    run <= 1'b0;
    chk("masked takes", 0, n_take);
    apb(1'b0, IPV_FLAGS_OFS, 0);
    chk("masked flags", 32'(EV), rd);
  endtask : t_mask

  task automatic t_prio();
    left = EV;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, IPV_CTRL_OFS, 1);
      go();
      wait_take(RK[k], VC[k], 1);
      left[RK[k]] = 1'b0;
      settle();
      apb(1'b0, IPV_FLAGS_OFS, 0);
      chk("pending flags", 32'(left), rd);
    end
  endtask : t_prio

  task automatic t_hold();
    apb(1'b1, IPV_CTRL_OFS, 1);
    apb(1'b1, IPV_FLAGS_OFS, 32'h200);
    go();
    wait_take(9, 16'h0030, 2);
    settle();
  endtask : t_hold

  task automatic t_dsr();
    apb(1'b1, IPV_CTRL_OFS, 1);
    fire(21'h4);
    dsr_prefix_done <= 1'b1;
    go();
    @(posedge pclk iff instr_done === 1'b1);
    dsr_prefix_done <= 1'b0;
    wait_take(2, 16'h0010, 2);
    settle();
  endtask : t_dsr

  task automatic t_nmi();
    fire(21'hB);
    go();
    wait_take(0, 16'h0008, 1);
    wait_take(1, 16'h000A, 0);
    settle();
    chk("nmi depth", 2, 32'(exception_depth));
    chk("nmi gate", 0, 32'(master_irq_gate));
    apb(1'b0, IPV_FLAGS_OFS, 0);
    chk("masked left", 32'h8, rd);
    // last take rank 1, depth 2, entry finished, no write hold
    apb(1'b0, IPV_STATE_OFS, 0);
    chk("state reg", 32'h00000201, rd);
    return_from_trap_instr <= 1'b1;
    @(posedge pclk);
    return_from_trap_instr <= 1'b0;
    wait_load();
    // level-2 frame kept the status word with the gate bit low
    chk("nmi return status", 32'h52, 32'(status_load_value));
    chk("nmi return depth", 1, 32'(exception_depth));
  endtask : t_nmi

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    {presetn, psel, penable, pwrite, run, dsr_prefix_done} = '0;
    {soft_trap_instr, return_from_trap_instr} = '0;
    paddr = '0;
    pwdata = '0;
    source_events = '0;
    soft_trap_vector = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_trap();
    t_mask();
    t_prio();
    t_hold();
    t_dsr();
    t_nmi();
    end_of_test();
  end

  initial begin
    #200000;
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end
endmodule : ipv_controller_tb_top

bind ipv_controller ipv_sva ipv_sva_inst (.pclk, .presetn, .instr_done, .dsr_prefix_done,
  .soft_trap_instr, .return_from_trap_instr, .take_strobe, .take_source, .take_vector,
  .shift_busy, .pc_load, .pc_load_value, .status_load, .master_irq_gate, .exception_depth);

`default_nettype wire
